/* File: src/dhlcd_pkg.sv */
// package of constants and types for the dual half lcd bus driver
package dhlcd_pkg;
	localparam int DHLCD_DATA_W = 8;
	localparam int DHLCD_FIFO_DEPTH = 16;
	// controller bus timing
	localparam int DHLCD_CLK_MHZ = 125;
	localparam int DHLCD_STROBE_NS = 480;
	localparam int DHLCD_SETUP_NS = 140;
	localparam int DHLCD_STROBE_CYC = (DHLCD_STROBE_NS * DHLCD_CLK_MHZ + 999) / 1000;
	localparam int DHLCD_SETUP_CYC = (DHLCD_SETUP_NS * DHLCD_CLK_MHZ + 999) / 1000;
	localparam int DHLCD_CNT_W = 8;
	localparam int DHLCD_BUSY_BIT = 7;
	localparam int DHLCD_OP_W = 2;
	// request operations
	localparam logic [1:0] DHLCD_OP_CMD = 2'h0;
	localparam logic [1:0] DHLCD_OP_WRITE = 2'h1;
	localparam logic [1:0] DHLCD_OP_READ = 2'h2;
	localparam logic [1:0] DHLCD_OP_RMW = 2'h3;
	// address-set command bases
	localparam logic [7:0] DHLCD_CMD_SET_ROW = 8'hb8;
	localparam logic [7:0] DHLCD_CMD_SET_COL = 8'h40;
	localparam logic [2:0] DHLCD_ROW_RESET = 3'h0;
	localparam logic [5:0] DHLCD_COL_RESET = 6'h00;
	// request word: op, right half, reverse, first, set_addr, row, col, data
	localparam int DHLCD_REQ_W = 2 + 1 + 1 + 1 + 1 + 3 + 6 + 8;
	typedef enum logic [8:0] {
		DHLCD_IDLE = 9'b0_0000_0001,
		DHLCD_POLL_OLD = 9'b0_0000_0010,
		DHLCD_POLL_NEW = 9'b0_0000_0100,
		DHLCD_SETUP = 9'b0_0000_1000,
		DHLCD_STROBE = 9'b0_0001_0000,
		DHLCD_HOLD = 9'b0_0010_0000,
		DHLCD_NEXT = 9'b0_0100_0000,
		DHLCD_DONE = 9'b0_1000_0000,
		DHLCD_GAP = 9'b1_0000_0000
	} dhlcd_state_e;
endpackage

/* File: src/dhlcd_fifo.sv */
// request fifo between drawing logic and the bus sequencer
`timescale 1ns/1ps
`default_nettype none
module dhlcd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

/* File: src/dhlcd_driver.sv */
// host-side bus driver for a two-half dot-matrix lcd controller
// Overview of operation
// - readiness comes from polling the busy flag, never a fixed wait
// - each access first polls busy with the previous access's half select lines
// - when the half changes, poll busy again with the new half selected
// - select, read/write and half lines hold until the poll ends; only strobe moves
// - display reads start with one full dummy read whose data is dropped
// - column auto-increments, so only the first byte of a burst gets a dummy
// - writes carry no dummy cycle; the byte goes straight out
// - x address is the row (page), y address is the column
// - top-left corner is coordinate 0
// - each half is addressed by its own select; no page state is kept
// - control lines change in one registered step, with no glitch states
// - data bus returns to input as soon as a write ends
// - reverse mode inverts read data, merges, inverts again before write-back
`timescale 1ns/1ps
`default_nettype none
module dhlcd_driver
	import dhlcd_pkg::*;
#(
	parameter int FIFO_DEPTH = DHLCD_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic req_right,
	input wire logic req_reverse,
	input wire logic req_first,
	input wire logic req_set_addr,
	input wire logic [2:0] req_row,
	input wire logic [5:0] req_col,
	input wire logic [7:0] req_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic busy,
	output logic register_select_line,
	output logic read_write_line,
	output logic left_half_select,
	output logic right_half_select,
	output logic strobe_line,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	input wire logic [7:0] data_bus_in
);
	logic fifo_valid;
	logic fifo_pop;
	logic [DHLCD_REQ_W-1:0] fifo_word;
	logic fifo_in_ready;
	dhlcd_fifo #(.WIDTH(DHLCD_REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(req_valid),
		.in_ready(fifo_in_ready),
		.in_data({req_op, req_right, req_reverse, req_first, req_set_addr,
			req_row, req_col, req_data}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_word)
	);
	dhlcd_state_e state;
	logic [DHLCD_CNT_W-1:0] cnt;
	logic [1:0] op;
	logic right;
	logic reverse;
	logic dummy_pend;
	logic [2:0] step;
	logic [2:0] row;
	logic [5:0] col;
	logic [7:0] wdata;
	logic [7:0] merged;
	logic cur_right;
	logic cur_rs;
	logic cur_rw;
	logic [7:0] cur_out;
	logic cur_oe;
	logic poll_phase;
	// step plan: 0 row cmd, 1 col cmd, 2 dummy read, 3 data read, 4 data write
	localparam logic [2:0] STEP_ROW = 3'h0;
	localparam logic [2:0] STEP_COL = 3'h1;
	localparam logic [2:0] STEP_DUMMY = 3'h2;
	localparam logic [2:0] STEP_READ = 3'h3;
	localparam logic [2:0] STEP_WRITE = 3'h4;
	localparam logic [2:0] STEP_CMD = 3'h5;
	assign fifo_pop = (state == DHLCD_IDLE) && fifo_valid;
	assign poll_phase = (state == DHLCD_POLL_OLD) || (state == DHLCD_POLL_NEW);
	// reverse: invert read-back, merge ones, invert again for write-back
	assign merged = reverse ? ~((~data_bus_in) | wdata) : (data_bus_in | wdata);
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			state <= DHLCD_IDLE;
			cnt <= '0;
			op <= DHLCD_OP_CMD;
			right <= 1'b0;
			reverse <= 1'b0;
			dummy_pend <= 1'b0;
			step <= STEP_CMD;
			row <= DHLCD_ROW_RESET;
			col <= DHLCD_COL_RESET;
			wdata <= 8'h00;
			cur_right <= 1'b0;
			cur_rs <= 1'b0;
			cur_rw <= 1'b1;
			cur_out <= 8'h00;
			cur_oe <= 1'b0;
		end
		else
		begin
			unique case (state)
				DHLCD_IDLE:
				begin
					cur_oe <= 1'b0;
					if (fifo_valid)
					begin
						{op, right, reverse, dummy_pend} <= fifo_word[22:18];
						row <= fifo_word[16:14];
						col <= fifo_word[13:8];
						wdata <= fifo_word[7:0];
						// address set only when asked; half is carried per request
						// a read burst goes on from the output register without a dummy
						if (fifo_word[17])
							step <= STEP_ROW;
						else if (fifo_word[22:21] == DHLCD_OP_WRITE)
							step <= STEP_WRITE;
						else if (fifo_word[22:21] == DHLCD_OP_CMD)
							step <= STEP_CMD;
						else
							step <= fifo_word[18] ? STEP_DUMMY : STEP_READ;
						// status poll keeps previous half and select lines
						state <= DHLCD_POLL_OLD;
						cnt <= '0;
					end
				end
				DHLCD_POLL_OLD, DHLCD_POLL_NEW:
				begin
					// status read: only strobe toggles here
					cur_rs <= 1'b0;
					cur_rw <= 1'b1;
					cur_oe <= 1'b0;
					if (cnt == DHLCD_CNT_W'(DHLCD_STROBE_CYC + DHLCD_SETUP_CYC))
					begin
						cnt <= '0;
						if (!data_bus_in[DHLCD_BUSY_BIT])
						begin
							if (state == DHLCD_POLL_OLD && right != cur_right)
							begin
								cur_right <= right;
								state <= DHLCD_POLL_NEW;
							end
							else
								state <= DHLCD_SETUP;
						end
					end
					else
						cnt <= cnt + 1'b1;
				end
				DHLCD_SETUP:
				begin
					// all lines set together from registers
					unique case (step)
						STEP_ROW:
						begin
							{cur_rs, cur_rw, cur_oe} <= 3'b001;
							cur_out <= DHLCD_CMD_SET_ROW | {5'h00, row};
						end
						STEP_COL:
						begin
							{cur_rs, cur_rw, cur_oe} <= 3'b001;
							cur_out <= DHLCD_CMD_SET_COL | {2'h0, col};
						end
						STEP_DUMMY, STEP_READ:
						begin
							{cur_rs, cur_rw, cur_oe} <= 3'b110;
						end
						STEP_WRITE:
						begin
							// byte and direction move on the same edge
							{cur_rs, cur_rw, cur_oe} <= 3'b101;
							cur_out <= wdata;
						end
						default:
						begin
							{cur_rs, cur_rw, cur_oe} <= {op == DHLCD_OP_WRITE, 2'b01};
							cur_out <= wdata;
						end
					endcase
					cnt <= '0;
					state <= DHLCD_STROBE;
				end
				DHLCD_STROBE:
				begin
					if (cnt == DHLCD_CNT_W'(DHLCD_STROBE_CYC + DHLCD_SETUP_CYC))
					begin
						cnt <= '0;
						state <= DHLCD_HOLD;
						if (step == STEP_READ && op == DHLCD_OP_RMW)
							wdata <= merged;
					end
					else
						cnt <= cnt + 1'b1;
				end
				DHLCD_HOLD:
				begin
					// drive ends with the strobe; select lines stay for hold time
					cur_oe <= 1'b0;
					state <= DHLCD_NEXT;
				end
				DHLCD_NEXT:
				begin
					state <= DHLCD_POLL_OLD;
					unique case (step)
						STEP_ROW: step <= STEP_COL;
						STEP_COL:
						begin
							// a command request with set_addr stops once the address is set
							if (op == DHLCD_OP_CMD)
								state <= DHLCD_DONE;
							step <= (op == DHLCD_OP_WRITE) ? STEP_WRITE :
								(dummy_pend ? STEP_DUMMY : STEP_READ);
						end
						STEP_DUMMY:
						begin
							dummy_pend <= 1'b0;
							step <= STEP_READ;
						end
						STEP_READ:
						begin
							if (op == DHLCD_OP_RMW)
							begin
								step <= STEP_COL; // column moved on after the read
								dummy_pend <= 1'b0;
								op <= DHLCD_OP_WRITE;
							end
							else
								state <= DHLCD_DONE;
						end
						default: state <= DHLCD_DONE;
					endcase
				end
				DHLCD_DONE:
					state <= DHLCD_GAP;
				DHLCD_GAP:
					state <= DHLCD_IDLE;
			endcase
		end
	end
	// pin drivers: every line comes straight from a flop
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			register_select_line <= 1'b0;
			read_write_line <= 1'b1;
			left_half_select <= 1'b1;
			right_half_select <= 1'b0;
			strobe_line <= 1'b0;
			data_bus_out <= 8'h00;
			data_bus_oe <= 1'b0;
		end
		else
		begin
			// lines held stable across a poll; only strobe toggles
			register_select_line <= poll_phase ? 1'b0 : cur_rs;
			read_write_line <= poll_phase ? 1'b1 : cur_rw;
			left_half_select <= !cur_right;
			right_half_select <= cur_right;
			strobe_line <= (poll_phase || state == DHLCD_STROBE) &&
				cnt >= DHLCD_CNT_W'(DHLCD_SETUP_CYC);
			data_bus_out <= cur_out;
			data_bus_oe <= cur_oe && (state == DHLCD_STROBE || state == DHLCD_SETUP);
		end
	end
	// read result: the last strobe cycle still has the controller driving the bus
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end
		else
		begin
			rd_valid <= state == DHLCD_STROBE && step == STEP_READ && op == DHLCD_OP_READ &&
				cnt == DHLCD_CNT_W'(DHLCD_STROBE_CYC + DHLCD_SETUP_CYC);
			if (state == DHLCD_STROBE && step == STEP_READ)
				rd_data <= reverse ? ~data_bus_in : data_bus_in;
		end
	end
	// status towards the drawing logic
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			busy <= 1'b0;
			req_ready <= 1'b0;
		end
		else
		begin
			busy <= state != DHLCD_IDLE || fifo_valid;
			req_ready <= fifo_in_ready;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/dhlcd_driver_properties.sv */
// concurrent checks on the lcd bus driver ports
`timescale 1ns/1ps
`default_nettype none
module dhlcd_driver_checker
	import dhlcd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic rd_valid,
	input wire logic register_select_line,
	input wire logic read_write_line,
	input wire logic left_half_select,
	input wire logic right_half_select,
	input wire logic strobe_line,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe,
	input wire logic [7:0] data_bus_in
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	logic st_rd;
	logic [3:0] ctl;
	assign st_rd = read_write_line && !register_select_line;
	assign ctl = {register_select_line, read_write_line, left_half_select, right_half_select};
	AST_ONE_HALF: assert property (left_half_select != right_half_select)
		else $error("half selects not exclusive");
	AST_CTRL_HOLD: assert property (strobe_line && $past(strobe_line) |-> $stable(ctl))
		else $error("control lines moved under strobe");
	AST_OE_WRITE: assert property (data_bus_oe |-> !read_write_line)
		else $error("data bus driven outside a write");
	AST_OE_RELEASE: assert property (
		$fell(strobe_line) && !read_write_line |-> ##[0:40] !data_bus_oe)
		else $error("data bus kept after write");
	AST_DATA_HOLD: assert property (data_bus_oe && $past(data_bus_oe) |-> $stable(data_bus_out))
		else $error("driven data changed mid write");
	AST_RD_LINES: assert property (rd_valid |-> register_select_line && read_write_line)
		else $error("read result without data read");
	// a poll that saw busy must repeat as a status read on the same lines
	AST_POLL_AGAIN: assert property (
		$fell(strobe_line) && st_rd && $past(data_bus_in[DHLCD_BUSY_BIT])
		|-> (st_rd && $stable(ctl)) throughout (##[1:200] strobe_line))
		else $error("busy poll not repeated");
	AST_HALF_POLL: assert property (
		$changed(ctl[1:0]) |-> st_rd throughout (##[1:200] strobe_line))
		else $error("half change without poll");
	COV_READ: cover property (rd_valid);
	COV_HALF: cover property ($changed(right_half_select));
	COV_POLL: cover property ($fell(strobe_line) && st_rd && $past(data_bus_in[DHLCD_BUSY_BIT]));
endmodule
bind dhlcd_driver dhlcd_driver_checker u_chk (.core_clk, .rstn, .rd_valid, .register_select_line,
	.read_write_line, .left_half_select, .right_half_select, .strobe_line, .data_bus_out,
	.data_bus_oe, .data_bus_in);
`default_nettype wire

/* File: testbench/dhlcd_panel_model.sv */
// behavioural two-half dot-matrix controller
`timescale 1ns/1ps
`default_nettype none
module dhlcd_panel_model (
	input wire logic core_clk,
	input wire logic register_select_line,
	input wire logic read_write_line,
	input wire logic right_half_select,
	input wire logic strobe_line,
	input wire logic [7:0] data_bus_out,
	input wire logic [7:0] busy_len,
	output logic [7:0] data_bus_in,
	output int viol
);
	logic [7:0] mem [2][512];
	logic [2:0] row [2];
	logic [5:0] col [2];
	logic [7:0] outreg [2];
	logic [7:0] bcnt [2] = '{8'h00, 8'h00};
	logic [7:0] last = 8'h00;
	logic [10:0] cap = 11'h000;
	logic prev = 1'b0;
	logic h;
	initial
		viol = 0;
	assign h = cap[8];
	// a released bus shows the inverse of the last byte, so stale data never passes
	always_comb
		if (strobe_line && read_write_line)
			data_bus_in = register_select_line ? outreg[right_half_select]
				: {bcnt[right_half_select] != 8'h00, 7'h00};
		else
			data_bus_in = ~last;
	always @(posedge core_clk)
	begin
		prev <= strobe_line;
		for (int i = 0; i < 2; i++)
			if (bcnt[i] != 8'h00)
				bcnt[i] <= bcnt[i] - 8'h01;
		if (strobe_line)
		begin
			cap <= {register_select_line, read_write_line, right_half_select, data_bus_out};
			last <= data_bus_in;
		end
		if (prev && !strobe_line && (cap[10] || !cap[9]))
		begin
			if (bcnt[h] != 8'h00)
				viol <= viol + 1;
			bcnt[h] <= busy_len;
			if (cap[9])
				outreg[h] <= mem[h][{row[h], col[h]}];
			else if (cap[10])
				mem[h][{row[h], col[h]}] <= cap[7:0];
			if (cap[10])
				col[h] <= col[h] + 6'h01;
			else if (cap[7:3] == 5'b10111)
				row[h] <= cap[2:0];
			else if (cap[7:6] == 2'b01)
				col[h] <= cap[5:0];
		end
	end
endmodule
`default_nettype wire

/* File: testbench/test_dhlcd_driver.sv */
// self-checking bench for the lcd bus driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) \
		begin \
			n_errors++; \
			$display("MISMATCH %s exp %h got %h", nm, ex, got); \
		end \
	end
module test_dhlcd_driver
	import dhlcd_pkg::*;
;
	logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_right = 1'b0, req_reverse = 1'b0;
	logic req_first = 1'b0, req_set_addr = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [2:0] req_row = 3'h0;
	logic [5:0] req_col = 6'h00;
	logic [7:0] req_data = 8'h00, busy_len = 8'h00;
	logic req_ready, rd_valid, busy, register_select_line, read_write_line, left_half_select;
	logic right_half_select, strobe_line, data_bus_oe;
	logic [7:0] rd_data, data_bus_out, data_bus_in, e, x, n;
	logic [7:0] d [20];
	logic [7:0] expq [$];
	logic [31:0] seed = 32'h0000_0040;
	int n_errors = 0, cmp_count = 0, viol;
	dhlcd_driver #(.FIFO_DEPTH(16)) DUT (.core_clk, .rstn, .req_valid, .req_ready, .req_op,
		.req_right, .req_reverse, .req_first, .req_set_addr, .req_row, .req_col, .req_data,
		.rd_valid, .rd_data, .busy, .register_select_line, .read_write_line, .left_half_select,
		.right_half_select, .strobe_line, .data_bus_out, .data_bus_oe, .data_bus_in);
	dhlcd_panel_model lcd (.core_clk, .register_select_line, .read_write_line, .right_half_select,
		.strobe_line, .data_bus_out, .busy_len, .data_bus_in, .viol);
	initial
		forever
			#4 core_clk = ~core_clk;
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// two idle edges let the lagging ready flag catch up before the next push
	task automatic push(input logic [1:0] op, input logic rt, rv, fi, sa, input logic [2:0] r,
		input logic [5:0] c, input logic [7:0] v);
		repeat (2) @(posedge core_clk);
		while (req_ready !== 1'b1)
			@(posedge core_clk);
		{req_valid, req_op, req_right, req_reverse, req_first, req_set_addr, req_row, req_col,
			req_data} <= {1'b1, op, rt, rv, fi, sa, r, c, v};
		@(posedge core_clk);
		req_valid <= 1'b0;
	endtask
	task automatic wait_idle();
		repeat (3) @(posedge core_clk);
		repeat (40000) if (busy !== 1'b0) @(posedge core_clk);
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
		if (rd_valid === 1'b1)
		begin
			`CHK("read expected", 1'b1, expq.size() > 0)
			if (expq.size() > 0)
			begin
				e = expq.pop_front();
				`CHK("read byte", e, rd_data)
			end
		end
	initial
	begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		busy_len <= 8'h20;
		for (int i = 0; i < 20; i++)
		begin
			seed = xs(seed);
			d[i] = seed[7:0];
			push(DHLCD_OP_WRITE, 1'b0, 1'b0, 1'b0, i == 0, 3'h0, 6'h00, d[i]);
		end
		wait_idle();
		for (int i = 0; i < 20; i++)
			`CHK("panel byte", d[i], lcd.mem[0][i])
		busy_len <= 8'h00;
		for (int i = 0; i < 4; i++)
		begin
			expq.push_back(d[i]);
			push(DHLCD_OP_READ, 1'b0, 1'b0, i == 0, i == 0, 3'h0, 6'h00, 8'h00);
		end
		busy_len <= 8'hc8;
		seed = xs(seed);
		x = seed[7:0];
		n = seed[15:8];
		push(DHLCD_OP_WRITE, 1'b1, 1'b0, 1'b0, 1'b1, 3'h5, 6'h09, x);
		expq.push_back(d[4]);
		push(DHLCD_OP_READ, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 6'h04, 8'h00);
		expq.push_back(x);
		push(DHLCD_OP_READ, 1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 6'h09, 8'h00);
		push(DHLCD_OP_CMD, 1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 6'h03, 8'h00);
		push(DHLCD_OP_WRITE, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, ~x);
		push(DHLCD_OP_RMW, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 6'h05, n);
		push(DHLCD_OP_RMW, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 6'h06, n);
		wait_idle();
		`CHK("addressed byte", ~x, lcd.mem[1][2 * 64 + 3])
		`CHK("reverse merge", ~(~d[5] | n), lcd.mem[0][5])
		`CHK("plain merge", d[6] | n, lcd.mem[0][6])
		push(DHLCD_OP_CMD, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, DHLCD_CMD_SET_ROW | 8'h03);
		push(DHLCD_OP_CMD, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, DHLCD_CMD_SET_COL | 8'h07);
		push(DHLCD_OP_WRITE, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 6'h00, n);
		expq.push_back(~d[5] | n);
		push(DHLCD_OP_READ, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 6'h05, 8'h00);
		wait_idle();
		`CHK("reads left", 0, expq.size())
		`CHK("raw command write", n, lcd.mem[0][3 * 64 + 7])
		`CHK("access while busy", 0, viol)
		stop_test();
	end
	initial
	begin
		#(8 * 60000);
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
